// >>> rtl/flj_pkg.sv
// shared constants and types for the frequency limit and jump block
package flj_pkg;

	// frequencies are unsigned counts of 0.1 Hz
	typedef logic [15:0] flj_freq_t;

	// setting value meaning "function disabled" (9999 raw, outside every real range)
	localparam flj_freq_t FLJ_DISABLED = 16'h270F;
	localparam flj_freq_t FLJ_UPPER_MAX = 16'h04B0;
	localparam flj_freq_t FLJ_CEIL_MAX = 16'h170C;
	localparam flj_freq_t FLJ_WIDTH_MAX = 16'h012C;

	localparam flj_freq_t FLJ_UPPER_RST = 16'h04B0;
	localparam flj_freq_t FLJ_LOWER_RST = 16'h0000;
	localparam flj_freq_t FLJ_CEIL_RST = 16'h04B0;
	localparam flj_freq_t FLJ_START_RST = 16'h0005;
	localparam flj_freq_t FLJ_JOG_RST = 16'h0032;

	localparam logic [11:0] FLJ_ADDR_UPPER = 12'h000;
	localparam logic [11:0] FLJ_ADDR_LOWER = 12'h004;
	localparam logic [11:0] FLJ_ADDR_CEIL = 12'h008;
	localparam logic [11:0] FLJ_ADDR_START = 12'h00C;
	localparam logic [11:0] FLJ_ADDR_JOG = 12'h010;
	localparam logic [11:0] FLJ_ADDR_JUMP0 = 12'h014;
	localparam logic [11:0] FLJ_ADDR_JUMP5 = 12'h028;
	localparam logic [11:0] FLJ_ADDR_WIDTH = 12'h02C;
	localparam logic [11:0] FLJ_ADDR_STATUS = 12'h030;
	localparam logic [11:0] FLJ_ADDR_MASK = 12'h034;
	localparam logic [11:0] FLJ_ADDR_OUT = 12'h038;
	localparam logic [11:0] FLJ_ADDR_STEP = 12'h004;

	// status / mask bit positions
	localparam int FLJ_ST_WERR = 0;
	localparam int FLJ_ST_HI = 1;
	localparam int FLJ_ST_LO = 2;
	localparam int FLJ_ST_W = 3;

	localparam logic [1:0] FLJ_RESP_OKAY = 2'h0;
	localparam logic [1:0] FLJ_RESP_SLVERR = 2'h2;

	typedef struct packed {
		flj_freq_t [5:0] pt;
		flj_freq_t width;
	} flj_jump_cfg_t;

	typedef enum logic [1:0] {
		FLJ_WR_IDLE = 2'b01,
		FLJ_WR_RESP = 2'b10
	} flj_wr_state_t;

endpackage

// >>> rtl/flj_jump.sv
// resonance band jump: three-point and six-point modes, combinational
`timescale 1ns/1ps
`default_nettype none
module flj_jump import flj_pkg::*; (
	input wire flj_jump_cfg_t cfg,
	input wire flj_freq_t set_freq,
	input wire logic falling,
	output flj_freq_t jumped_freq,
	output logic replaced
);

	flj_freq_t lo;
	flj_freq_t hi;
	flj_freq_t alo;
	flj_freq_t ahi;
	flj_freq_t pa;
	flj_freq_t pb;
	logic hit;

	always_comb begin
		jumped_freq = set_freq;
		replaced = 1'b0;
		lo = set_freq;
		hi = set_freq;
		alo = 16'h0000;
		ahi = 16'h0000;
		pa = 16'h0000;
		pb = 16'h0000;
		hit = 1'b0;
		if (cfg.width == 16'h0000) begin
			// zero width turns every jump off
			jumped_freq = set_freq;
		end else if (cfg.width == FLJ_DISABLED) begin
			// three-point: run at the A setting of the band, top or bottom alike
			for (int k = 0; k < 3; k++) begin
				pa = cfg.pt[2*k];
				pb = cfg.pt[2*k+1];
				if (!replaced && pa != FLJ_DISABLED && pb != FLJ_DISABLED) begin
					lo = (pa < pb) ? pa : pb;
					hi = (pa < pb) ? pb : pa;
					if (set_freq >= lo && set_freq <= hi) begin
						jumped_freq = pa;
						replaced = 1'b1;
					end
				end
			end
		end else begin
			// six-point: grow one band over every overlapping area; six passes reach any chain
			for (int p = 0; p < 6; p++) begin
				for (int i = 0; i < 6; i++) begin
					if (cfg.pt[i] != FLJ_DISABLED) begin
						alo = (cfg.pt[i] > cfg.width) ? cfg.pt[i] - cfg.width : 16'h0000;
						ahi = cfg.pt[i] + cfg.width;
						if (alo <= hi && ahi >= lo) begin
							hit = 1'b1;
							lo = (alo < lo) ? alo : lo;
							hi = (ahi > hi) ? ahi : hi;
						end
					end
				end
			end
			if (hit) begin
				jumped_freq = falling ? hi : lo;
				replaced = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> rtl/flj_freq_limit.sv
// frequency command limiter with resonance jump and AXI4-Lite register file
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module flj_freq_limit import flj_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire flj_freq_t cmd_freq,
	input wire logic cmd_valid,
	input wire logic start_req,
	input wire logic jog_req,
	input wire logic ramping,
	input wire logic sensorless,
	input wire flj_freq_t ctrl_freq,
	input wire logic stall_active,
	input wire flj_freq_t stall_freq,
	output flj_freq_t limited_cmd,
	output flj_freq_t out_freq,
	output logic irq
);

	flj_freq_t upper_freq_limit_q;
	flj_freq_t lower_freq_limit_q;
	flj_freq_t high_speed_ceiling_q;
	flj_freq_t starting_freq_q;
	flj_freq_t jog_freq_q;
	flj_jump_cfg_t jump_cfg_q;
	logic [FLJ_ST_W-1:0] status_q;
	logic [FLJ_ST_W-1:0] mask_q;
	flj_freq_t limited_q;
	flj_freq_t out_q;
	flj_freq_t prev_set_q;
	logic falling_q;

	flj_wr_state_t wr_state_q;
	logic aw_have_q;
	logic w_have_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	function automatic logic [31:0] reg_word(input logic [11:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			FLJ_ADDR_UPPER: r[15:0] = upper_freq_limit_q;
			FLJ_ADDR_LOWER: r[15:0] = lower_freq_limit_q;
			FLJ_ADDR_CEIL: r[15:0] = high_speed_ceiling_q;
			FLJ_ADDR_START: r[15:0] = starting_freq_q;
			FLJ_ADDR_JOG: r[15:0] = jog_freq_q;
			FLJ_ADDR_WIDTH: r[15:0] = jump_cfg_q.width;
			FLJ_ADDR_STATUS: r[FLJ_ST_W-1:0] = status_q;
			FLJ_ADDR_MASK: r[FLJ_ST_W-1:0] = mask_q;
			FLJ_ADDR_OUT: r[15:0] = out_q;
			default: begin
				for (int i = 0; i < 6; i++) begin
					if (a == FLJ_ADDR_JUMP0 + 12'(i * 4)) begin
						r[15:0] = jump_cfg_q.pt[i];
					end
				end
			end
		endcase
		return r;
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return a <= FLJ_ADDR_OUT;
	endfunction

	// true when two enabled A/B pairs cover a common frequency
	function automatic logic pairs_overlap(input flj_jump_cfg_t c);
		logic r;
		flj_freq_t lo [3];
		flj_freq_t hi [3];
		logic en [3];
		r = 1'b0;
		for (int k = 0; k < 3; k++) begin
			en[k] = c.pt[2*k] != FLJ_DISABLED && c.pt[2*k+1] != FLJ_DISABLED;
			lo[k] = (c.pt[2*k] < c.pt[2*k+1]) ? c.pt[2*k] : c.pt[2*k+1];
			hi[k] = (c.pt[2*k] < c.pt[2*k+1]) ? c.pt[2*k+1] : c.pt[2*k];
		end
		for (int p = 0; p < 2; p++) begin
			for (int q = p + 1; q < 3; q++) begin
				if (en[p] && en[q] && lo[p] <= hi[q] && lo[q] <= hi[p]) begin
					r = 1'b1;
				end
			end
		end
		return r;
	endfunction

	// write path: address and data may arrive in either order
	logic wr_fire;
	logic [11:0] wa;
	logic [31:0] old_w;
	flj_freq_t wv;
	logic wr_map;
	logic wr_ok;
	logic wr_reject;
	flj_jump_cfg_t cand;

	assign wr_fire = wr_state_q == FLJ_WR_IDLE && aw_have_q && w_have_q;
	assign awready = wr_state_q == FLJ_WR_IDLE && !aw_have_q;
	assign wready = wr_state_q == FLJ_WR_IDLE && !w_have_q;
	assign bvalid = wr_state_q == FLJ_WR_RESP;
	assign bresp = bresp_q;

	always_comb begin
		wa = {aw_addr_q[11:2], 2'b00};
		old_w = reg_word(wa);
		wv[7:0] = w_strb_q[0] ? w_data_q[7:0] : old_w[7:0];
		wv[15:8] = w_strb_q[1] ? w_data_q[15:8] : old_w[15:8];
		cand = jump_cfg_q;
		wr_map = is_mapped(wa);
		wr_ok = wr_map;
		case (wa)
			FLJ_ADDR_UPPER, FLJ_ADDR_LOWER: wr_ok = wv <= FLJ_UPPER_MAX;
			FLJ_ADDR_CEIL, FLJ_ADDR_START, FLJ_ADDR_JOG: wr_ok = wv <= FLJ_CEIL_MAX;
			FLJ_ADDR_WIDTH: wr_ok = wv <= FLJ_WIDTH_MAX || wv == FLJ_DISABLED;
			default: begin
				for (int i = 0; i < 6; i++) begin
					if (wa == FLJ_ADDR_JUMP0 + 12'(i * 4)) begin
						cand.pt[i] = wv;
						wr_ok = (wv <= FLJ_CEIL_MAX || wv == FLJ_DISABLED) && !pairs_overlap(cand);
					end
				end
			end
		endcase
		wr_reject = wr_fire && wr_map && !wr_ok;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
		end else if (awvalid && awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= awaddr[11:0];
		end else if (bvalid && bready) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (bvalid && bready) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_state_q <= FLJ_WR_IDLE;
			bresp_q <= FLJ_RESP_OKAY;
		end else begin
			case (wr_state_q)
				FLJ_WR_IDLE: begin
					if (wr_fire) begin
						wr_state_q <= FLJ_WR_RESP;
						bresp_q <= wr_ok ? FLJ_RESP_OKAY : FLJ_RESP_SLVERR;
					end
				end
				FLJ_WR_RESP: begin
					if (bready) begin
						wr_state_q <= FLJ_WR_IDLE;
					end
				end
				default: wr_state_q <= FLJ_WR_IDLE;
			endcase
		end
	end

	// upper limit and ceiling always carry the same value after either write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_freq_limit_q <= FLJ_UPPER_RST;
			high_speed_ceiling_q <= FLJ_CEIL_RST;
		end else if (wr_fire && wr_ok && (wa == FLJ_ADDR_UPPER || wa == FLJ_ADDR_CEIL)) begin
			upper_freq_limit_q <= wv;
			high_speed_ceiling_q <= wv;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lower_freq_limit_q <= FLJ_LOWER_RST;
			starting_freq_q <= FLJ_START_RST;
			jog_freq_q <= FLJ_JOG_RST;
			mask_q <= '0;
		end else if (wr_fire && wr_ok) begin
			if (wa == FLJ_ADDR_LOWER) lower_freq_limit_q <= wv;
			if (wa == FLJ_ADDR_START) starting_freq_q <= wv;
			if (wa == FLJ_ADDR_JOG) jog_freq_q <= wv;
			if (wa == FLJ_ADDR_MASK) mask_q <= wv[FLJ_ST_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			jump_cfg_q <= {7{FLJ_DISABLED}};
		end else if (wr_fire && wr_ok) begin
			jump_cfg_q <= cand;
			if (wa == FLJ_ADDR_WIDTH) jump_cfg_q.width <= wv;
		end
	end

	// read path: one register stage, next address taken once the answer is consumed
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= FLJ_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= reg_word({araddr[11:2], 2'b00});
			rresp_q <= is_mapped({araddr[11:2], 2'b00}) ? FLJ_RESP_OKAY : FLJ_RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// command path
	logic run;
	logic start_only;
	logic falling;
	flj_freq_t base;
	flj_freq_t j_out;
	logic j_rep;
	flj_freq_t set_j;
	logic jrep;
	flj_freq_t lim;
	logic hi_evt;
	logic lo_evt;

	assign run = start_req || jog_req;
	assign start_only = !jog_req && !cmd_valid;
	assign base = jog_req ? jog_freq_q : (cmd_valid ? cmd_freq : 16'h0000);
	// a steady command keeps the last direction so a band edge is not flipped
	assign falling = (base != prev_set_q) ? (base < prev_set_q) : falling_q;

	flj_jump u_jump (
		.cfg(jump_cfg_q),
		.set_freq(base),
		.falling(falling),
		.jumped_freq(j_out),
		.replaced(j_rep)
	);

	always_comb begin
		set_j = ramping ? base : j_out;
		jrep = !ramping && j_rep;
		hi_evt = 1'b0;
		lo_evt = 1'b0;
		if (!run) begin
			lim = 16'h0000;
		end else if (start_only) begin
			lim = (lower_freq_limit_q >= starting_freq_q) ? lower_freq_limit_q : 16'h0000;
		end else if (set_j > high_speed_ceiling_q) begin
			lim = high_speed_ceiling_q;
			hi_evt = 1'b1;
		end else if (jog_req && jog_freq_q <= lower_freq_limit_q) begin
			lim = jog_freq_q;
		end else if (jrep && set_j < lower_freq_limit_q) begin
			lim = set_j;
		end else if (set_j <= lower_freq_limit_q) begin
			lim = lower_freq_limit_q;
			lo_evt = set_j < lower_freq_limit_q;
		end else begin
			lim = set_j;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_set_q <= 16'h0000;
			falling_q <= 1'b0;
		end else begin
			prev_set_q <= base;
			falling_q <= falling;
		end
	end

	// limits act on the command; the final output may leave them under other control
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			limited_q <= 16'h0000;
			out_q <= 16'h0000;
		end else begin
			limited_q <= lim;
			if (stall_active) out_q <= stall_freq;
			else if (sensorless) out_q <= ctrl_freq;
			else out_q <= lim;
		end
	end

	assign limited_cmd = limited_q;
	assign out_freq = out_q;

	// sticky events, a new event wins over a write-one clear in the same cycle
	logic [FLJ_ST_W-1:0] st_set;
	logic [FLJ_ST_W-1:0] st_clr;
	assign st_set = {lo_evt, hi_evt, wr_reject};
	assign st_clr = (wr_fire && wr_ok && wa == FLJ_ADDR_STATUS) ? wv[FLJ_ST_W-1:0] : '0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~st_clr) | st_set;
		end
	end

	assign irq = |(status_q & mask_q);

	// checks
	sequence s_limit_write;
		wr_fire && wr_ok && (wa == FLJ_ADDR_UPPER || wa == FLJ_ADDR_CEIL);
	endsequence

	sequence s_start_only;
		start_req && start_only && lower_freq_limit_q >= starting_freq_q;
	endsequence

	a_upper_clamp: assert property (@(posedge clk) disable iff (!reset_n)
		run && !start_only && set_j > high_speed_ceiling_q |=> limited_cmd == $past(high_speed_ceiling_q))
		else $error("command above ceiling not clamped");

	a_limit_mirror: assert property (@(posedge clk) disable iff (!reset_n)
		s_limit_write |=> upper_freq_limit_q == $past(wv) && high_speed_ceiling_q == $past(wv))
		else $error("upper limit and ceiling not mirrored");

	a_lower_clamp: assert property (@(posedge clk) disable iff (!reset_n)
		run && !start_only && !jog_req && !jrep && set_j <= lower_freq_limit_q
		&& lower_freq_limit_q <= high_speed_ceiling_q |=> limited_cmd == $past(lower_freq_limit_q))
		else $error("command at or below lower limit not held at it");

	a_start_lower: assert property (@(posedge clk) disable iff (!reset_n)
		s_start_only |=> limited_cmd == $past(lower_freq_limit_q))
		else $error("start alone did not run at lower limit");

	a_jog_pref: assert property (@(posedge clk) disable iff (!reset_n)
		jog_req && jog_freq_q <= lower_freq_limit_q && set_j <= high_speed_ceiling_q
		|=> limited_cmd == $past(jog_freq_q))
		else $error("jog frequency not preferred over lower limit");

	a_ramp_pass: assert property (@(posedge clk) disable iff (!reset_n)
		ramping && cmd_valid && start_req && !jog_req && cmd_freq > lower_freq_limit_q
		&& cmd_freq <= high_speed_ceiling_q |=> limited_cmd == $past(cmd_freq))
		else $error("band jumped during ramp");

	a_write_reject: assert property (@(posedge clk) disable iff (!reset_n)
		wr_reject |=> status_q[FLJ_ST_WERR] && bvalid && bresp == FLJ_RESP_SLVERR && jump_cfg_q == $past(jump_cfg_q))
		else $error("overlapping jump write not rejected");

	a_jump_off: assert property (@(posedge clk) disable iff (!reset_n)
		jump_cfg_q.width == 16'h0000 |-> !j_rep && j_out == base)
		else $error("jump active with zero width");

	a_three_point: assert property (@(posedge clk) disable iff (!reset_n)
		jump_cfg_q.width == FLJ_DISABLED && j_rep
		|-> j_out == jump_cfg_q.pt[0] || j_out == jump_cfg_q.pt[2] || j_out == jump_cfg_q.pt[4])
		else $error("three-point jump not at an A setting");

	a_six_dir: assert property (@(posedge clk) disable iff (!reset_n)
		jump_cfg_q.width != FLJ_DISABLED && j_rep |-> (falling ? j_out >= base : j_out <= base))
		else $error("six-point jump went the wrong way");

	a_stall_pass: assert property (@(posedge clk) disable iff (!reset_n)
		stall_active |=> out_freq == $past(stall_freq))
		else $error("stall frequency not passed through");

	a_sensorless: assert property (@(posedge clk) disable iff (!reset_n)
		!stall_active && sensorless |=> out_freq == $past(ctrl_freq))
		else $error("sensorless output not taken from control");

endmodule
`default_nettype wire

// >>> bench/flj_src.sv
// model of the command source and the output frequency generator
`timescale 1ns/1ps
`default_nettype none
module flj_src import flj_pkg::*; (
	input wire logic clk,
	output flj_freq_t cmd_freq,
	output logic cmd_valid,
	output logic start_req,
	output logic jog_req,
	output logic ramping,
	output logic sensorless,
	output flj_freq_t ctrl_freq,
	output logic stall_active,
	output flj_freq_t stall_freq
);
	initial begin
		cmd_freq = 16'h0000;
		cmd_valid = 1'b0;
		start_req = 1'b0;
		jog_req = 1'b0;
		ramping = 1'b0;
		sensorless = 1'b0;
		ctrl_freq = 16'h0000;
		stall_active = 1'b0;
		stall_freq = 16'h0000;
	end

	// new command lands just after an edge, so the limiter samples it whole at the next one
	task automatic apply(input flj_freq_t f, input logic v, input logic st, input logic jg, input logic rp);
		@(posedge clk);
		cmd_freq <= f;
		cmd_valid <= v;
		start_req <= st;
		jog_req <= jg;
		ramping <= rp;
	endtask

	task automatic mode(input logic sl, input flj_freq_t cf, input logic sa, input flj_freq_t sf);
		@(posedge clk);
		sensorless <= sl;
		ctrl_freq <= cf;
		stall_active <= sa;
		stall_freq <= sf;
	endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the frequency limiter with resonance jump
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flj_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	flj_freq_t cmd_freq, ctrl_freq, stall_freq, limited_cmd, out_freq;
	logic cmd_valid, start_req, jog_req, ramping, sensorless, stall_active;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #50 clk = ~clk;

	flj_src src (.clk(clk), .cmd_freq(cmd_freq), .cmd_valid(cmd_valid), .start_req(start_req),
		.jog_req(jog_req), .ramping(ramping), .sensorless(sensorless), .ctrl_freq(ctrl_freq),
		.stall_active(stall_active), .stall_freq(stall_freq));

	flj_freq_limit dut (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .cmd_freq(cmd_freq), .cmd_valid(cmd_valid),
		.start_req(start_req), .jog_req(jog_req), .ramping(ramping), .sensorless(sensorless),
		.ctrl_freq(ctrl_freq), .stall_active(stall_active), .stall_freq(stall_freq),
		.limited_cmd(limited_cmd), .out_freq(out_freq), .irq(irq));

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// bready is raised with the request so the response is taken at the edge it is seen
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= {20'h0, a};
		wdata <= {16'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= {20'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, {16'h0, e}, "read data");
		chk({30'h0, rresp}, {30'h0, er}, "read response");
	endtask

	// one-cycle answer: sample just after the edge that follows the command
	// the output may differ from the limited command while stall or sensorless control owns it
	task automatic cfo(input flj_freq_t f, input logic v, input logic st, input logic jg, input logic rp,
		input flj_freq_t e, input flj_freq_t eo);
		src.apply(f, v, st, jg, rp);
		@(posedge clk);
		#1;
		chk({16'h0, limited_cmd}, {16'h0, e}, "limited command");
		chk({16'h0, out_freq}, {16'h0, eo}, "output frequency");
	endtask

	task automatic cf(input flj_freq_t f, input logic v, input logic st, input logic jg, input logic rp,
		input flj_freq_t e);
		cfo(f, v, st, jg, rp, e, e);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("BAD t=%0t watchdog expired", $time);
			results();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(FLJ_ADDR_UPPER, 16'h04B0, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_LOWER, 16'h0000, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_JUMP0, 16'h270F, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_WIDTH, 16'h270F, FLJ_RESP_OKAY);
		rd(12'h040, 16'h0000, FLJ_RESP_SLVERR);
		wr(12'h040, 16'h0001, FLJ_RESP_SLVERR);
		$display("test reset values done");
		wr(FLJ_ADDR_UPPER, 16'h0300, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_CEIL, 16'h0300, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_CEIL, 16'h1000, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_UPPER, 16'h1000, FLJ_RESP_OKAY);
		cf(16'h1200, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1000);
		wr(FLJ_ADDR_UPPER, 16'h04B0, FLJ_RESP_OKAY);
		cf(16'h0700, 1'b1, 1'b1, 1'b0, 1'b0, 16'h04B0);
		$display("test upper limit done");
		wr(FLJ_ADDR_LOWER, 16'h0064, FLJ_RESP_OKAY);
		cf(16'h0050, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0064);
		cf(16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0064);
		cf(16'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0032);
		$display("test lower limit done");
		wr(FLJ_ADDR_JUMP0 + 12'h008, 16'h012C, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_JUMP0 + 12'h00C, 16'h015E, FLJ_RESP_OKAY);
		cf(16'h0140, 1'b1, 1'b1, 1'b0, 1'b0, 16'h012C);
		cf(16'h0140, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0140);
		wr(FLJ_ADDR_JUMP0 + 12'h008, 16'h015E, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_JUMP0 + 12'h00C, 16'h012C, FLJ_RESP_OKAY);
		cf(16'h0140, 1'b1, 1'b1, 1'b0, 1'b0, 16'h015E);
		cf(16'h012C, 1'b1, 1'b1, 1'b0, 1'b0, 16'h015E);
		wr(FLJ_ADDR_JUMP0, 16'h0500, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_JUMP0 + 12'h004, 16'h0490, FLJ_RESP_OKAY);
		cf(16'h04A0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h04B0);
		wr(FLJ_ADDR_JUMP0 + 12'h010, 16'h0032, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_JUMP5, 16'h0046, FLJ_RESP_OKAY);
		cf(16'h003C, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0032);
		$display("test three-point jump done");
		wr(FLJ_ADDR_JUMP0 + 12'h010, 16'h0140, FLJ_RESP_SLVERR);
		rd(FLJ_ADDR_JUMP0 + 12'h010, 16'h0032, FLJ_RESP_OKAY);
		#1;
		chk({31'h0, irq}, 32'h0, "irq while masked");
		wr(FLJ_ADDR_MASK, 16'h0001, FLJ_RESP_OKAY);
		#1;
		chk({31'h0, irq}, 32'h1, "irq on write error");
		wr(FLJ_ADDR_STATUS, 16'h0001, FLJ_RESP_OKAY);
		#1;
		chk({31'h0, irq}, 32'h0, "irq after clear");
		$display("test write error done");
		src.mode(1'b0, 16'h0000, 1'b1, 16'h0010);
		cfo(16'h0050, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0064, 16'h0010);
		chk({16'h0, out_freq}, 32'h0010, "still stall output");
		src.mode(1'b1, 16'h0600, 1'b0, 16'h0000);
		src.apply(16'h0700, 1'b1, 1'b1, 1'b0, 1'b0);
		@(posedge clk);
		#1;
		chk({16'h0, limited_cmd}, 32'h04B0, "sensorless command");
		chk({16'h0, out_freq}, 32'h0600, "sensorless output");
		src.mode(1'b0, 16'h0000, 1'b0, 16'h0000);
		$display("test stall and sensorless done");
		wr(FLJ_ADDR_LOWER, 16'h0000, FLJ_RESP_OKAY);
		wr(FLJ_ADDR_WIDTH, 16'h000A, FLJ_RESP_OKAY);
		cf(16'h0014, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0014);
		cf(16'h0030, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0028);
		cf(16'h0064, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0064);
		cf(16'h0030, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0050);
		cf(16'h012C, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0122);
		wr(FLJ_ADDR_WIDTH, 16'h0000, FLJ_RESP_OKAY);
		cf(16'h0140, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0140);
		rd(FLJ_ADDR_OUT, 16'h0140, FLJ_RESP_OKAY);
		rd(FLJ_ADDR_STATUS, 16'h0006, FLJ_RESP_OKAY);
		$display("test six-point jump done");
		results();
	end
endmodule
`default_nettype wire
